// ===== src/aio_host_regs.sv
// Host register bank of the 8-channel analog input/output board
`timescale 1ns/10ps
`include "aio_regs.svh"
module aio_host_regs
	import aio_pkg::*;
#(
	parameter int INIT_CYCLES = `AIO_INIT_CYCLES,
	// Arbitrary value, stands for the installed revision
	parameter logic [15:0] FW_REVISION = 16'h0100
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Target access from the bus core
	input wire logic [31:0] cfg_base_addr,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_wdata,
	output logic bus_hit,
	output logic [31:0] bus_rdata,
	output logic bus_rd_valid,
	// Input buffer side
	input wire logic [15:0] in_sample,
	input wire logic [15:0] in_count,
	input wire logic [15:0] buf_flags,
	output logic in_pop,
	output logic in_buf_clear,
	// Output buffer side
	input wire logic [15:0] out_count,
	output logic out_wr,
	output logic [2:0] out_chan,
	output logic [15:0] out_value,
	// Scan sequencer
	input wire logic scan_active,
	input wire logic scan_done,
	output logic scan_start,
	output logic [3:0] scan_chan_count,
	// Output update
	input wire logic update_done,
	output logic out_strobe,
	output logic out_auto_update,
	// Mode outputs
	output logic [2:0] input_mode_field,
	output logic [2:0] loopback_select,
	output logic loopback_active,
	output logic [1:0] cal_mode,
	output logic [15:0] rate_value,
	output logic [15:0] rate_usage,
	// Events and interrupt
	input wire logic [7:0] irq_cond,
	output logic irq_req,
	// Connector pins
	input wire logic ext_trig,
	input wire logic ext_trig_ready,
	input wire logic ext_strobe,
	input wire logic ext_update_armed
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic is_burst_mode(input aio_mode_t m);
		return (m == AIO_MODE_SE_BURST) || (m == AIO_MODE_DIFF_BURST) ||
			(m == AIO_MODE_LOOPBACK) || (m == AIO_MODE_POS_REF) || (m == AIO_MODE_ZERO);
	endfunction

	function automatic logic at_offset(input logic [4:0] addr, input logic [4:0] off);
		return {addr[4:2], 2'b00} == off;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	aio_word_t ctrl_reg, ctrl_next;
	aio_word_t rate_reg, rate_next;
	aio_word_t use_reg, use_next;
	aio_word_t in_cnt_reg, in_cnt_next;
	aio_word_t out_cnt_reg, out_cnt_next;
	aio_word_t flags_reg, flags_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic pair_reg, pair_next;
	logic [2:0] chan_reg, chan_next;
	logic [2:0] ochan_reg, ochan_next;
	aio_word_t oval_reg, oval_next;
	logic owr_reg, owr_next;

	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic trig_fall;
	logic strb_fall;
	logic init_busy;
	logic init_done;
	logic init_start;
	logic scan_go;
	logic strobe_go;
	aio_mode_t mode;
	logic busy_scan;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Only address bits above the 32-byte block are compared
	assign hit = bus_addr[31:`AIO_BLOCK_LSB] == cfg_base_addr[31:`AIO_BLOCK_LSB];
	assign wr_hit = bus_wr & hit;
	assign rd_hit = bus_rd & hit;
	assign bus_hit = hit;

	assign mode = ctrl_reg[`AIO_CTL_MODE_HI:`AIO_CTL_MODE_LO];
	assign busy_scan = ctrl_reg[`AIO_CTL_BURST] | scan_active;

	// ----------------------------------------------------------------
	// Pin edges and init timer
	// ----------------------------------------------------------------
	aio_fall_detect u_trig (
		.clk(clk),
		.rst_b(rst_b),
		.pin(ext_trig),
		.ready(ext_trig_ready),
		.fall(trig_fall)
	);

	aio_fall_detect u_strobe (
		.clk(clk),
		.rst_b(rst_b),
		.pin(ext_strobe),
		.ready(ext_update_armed),
		.fall(strb_fall)
	);

	aio_init_timer #(
		.CYCLES(INIT_CYCLES)
	) u_init (
		.clk(clk),
		.rst_b(rst_b),
		.start(init_start),
		.busy(init_busy),
		.done(init_done)
	);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		init_start = 1'b0;
		scan_go = 1'b0;
		strobe_go = 1'b0;
		if (wr_hit && at_offset(bus_addr[4:0], `AIO_OFF_CONTROL)) begin
			// Plain fields take the written value
			ctrl_next[9:0] = bus_wdata[9:0];
			ctrl_next[`AIO_CTL_CAL_HI:`AIO_CTL_CAL_LO] = bus_wdata[12:11];
			if (!bus_wdata[`AIO_CTL_IRQ_FLAG]) begin
				ctrl_next[`AIO_CTL_IRQ_FLAG] = 1'b0;
			end
			if (bus_wdata[`AIO_CTL_SW_STRB] && !ctrl_reg[`AIO_CTL_SW_STRB]) begin
				strobe_go = 1'b1;
			end
			if (bus_wdata[`AIO_CTL_BURST] && !ctrl_reg[`AIO_CTL_BURST] &&
				!busy_scan && is_burst_mode(mode)) begin
				scan_go = 1'b1;
			end
			if (bus_wdata[`AIO_CTL_INIT] && !ctrl_reg[`AIO_CTL_INIT]) begin
				ctrl_next[`AIO_CTL_INIT] = 1'b1;
				init_start = 1'b1;
			end
		end
		// Ext trigger joins only when idle; a write in the same cycle merges
		if (trig_fall && !busy_scan && is_burst_mode(mode)) begin
			scan_go = 1'b1;
		end
		// Ext strobe counts only with strobing on and no strobe pending
		if (strb_fall && ctrl_reg[`AIO_CTL_STRB_EN] && !ctrl_reg[`AIO_CTL_SW_STRB]) begin
			strobe_go = 1'b1;
		end
		if (update_done) begin
			ctrl_next[`AIO_CTL_SW_STRB] = 1'b0;
		end
		if (strobe_go) begin
			ctrl_next[`AIO_CTL_SW_STRB] = 1'b1;
		end
		if (scan_done) begin
			ctrl_next[`AIO_CTL_BURST] = 1'b0;
		end
		if (scan_go) begin
			ctrl_next[`AIO_CTL_BURST] = 1'b1;
		end
		// Set wins over a clearing write in the same cycle
		if (irq_cond[ctrl_reg[`AIO_CTL_IRQ_HI:`AIO_CTL_IRQ_LO]]) begin
			ctrl_next[`AIO_CTL_IRQ_FLAG] = 1'b1;
		end
		if (init_done) begin
			ctrl_next = `AIO_CTRL_RESET;
			ctrl_next[`AIO_CTL_INIT] = 1'b0;
			ctrl_next[`AIO_CTL_IRQ_FLAG] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Rate registers and buffer status snapshots
	// ----------------------------------------------------------------
	always_comb begin
		rate_next = rate_reg;
		use_next = use_reg;
		if (wr_hit && at_offset(bus_addr[4:0], `AIO_OFF_RATE)) begin
			rate_next = bus_wdata[15:0];
		end
		if (wr_hit && at_offset(bus_addr[4:0], `AIO_OFF_RATE_USE)) begin
			use_next = bus_wdata[15:0];
		end
		if (init_done) begin
			rate_next = `AIO_RATE_RESET;
			use_next = `AIO_RATE_USE_RESET;
		end
		// Status is registered so reset shows fixed values
		in_cnt_next = in_count;
		out_cnt_next = out_count;
		flags_next = buf_flags;
	end

	// ----------------------------------------------------------------
	// Data port: read pops, writes pair channel then value
	// ----------------------------------------------------------------
	assign in_pop = rd_hit && at_offset(bus_addr[4:0], `AIO_OFF_DATA);
	assign in_buf_clear = init_done;

	always_comb begin
		pair_next = pair_reg;
		chan_next = chan_reg;
		ochan_next = ochan_reg;
		oval_next = oval_reg;
		owr_next = 1'b0;
		if (wr_hit && at_offset(bus_addr[4:0], `AIO_OFF_DATA)) begin
			if (!pair_reg) begin
				chan_next = bus_wdata[2:0];
				pair_next = 1'b1;
			end else begin
				ochan_next = chan_reg;
				oval_next = bus_wdata[15:0];
				owr_next = 1'b1;
				pair_next = 1'b0;
			end
		end
		// A half pair is dropped when the board reinitializes
		if (init_done) begin
			pair_next = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = rd_hit;
		if (rd_hit) begin
			rdata_next = 32'h00000000;
			unique case ({bus_addr[4:2], 2'b00})
				`AIO_OFF_CONTROL: rdata_next[15:0] = ctrl_reg;
				`AIO_OFF_RATE: rdata_next[15:0] = rate_reg;
				`AIO_OFF_DATA: rdata_next[15:0] = in_sample;
				`AIO_OFF_RATE_USE: rdata_next[15:0] = use_reg;
				`AIO_OFF_IN_COUNT: rdata_next[15:0] = in_cnt_reg;
				`AIO_OFF_FLAGS: rdata_next[15:0] = flags_reg;
				`AIO_OFF_FW_REV: rdata_next[15:0] = FW_REVISION;
				`AIO_OFF_OUT_COUNT: rdata_next[15:0] = out_cnt_reg;
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= `AIO_CTRL_RESET;
			rate_reg <= `AIO_RATE_RESET;
			use_reg <= `AIO_RATE_USE_RESET;
			in_cnt_reg <= `AIO_COUNT_RESET;
			out_cnt_reg <= `AIO_COUNT_RESET;
			flags_reg <= `AIO_FLAGS_RESET;
			rdata_reg <= 32'h00000000;
			rvalid_reg <= 1'b0;
			pair_reg <= 1'b0;
			chan_reg <= 3'h0;
			ochan_reg <= 3'h0;
			oval_reg <= 16'h0000;
			owr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			rate_reg <= rate_next;
			use_reg <= use_next;
			in_cnt_reg <= in_cnt_next;
			out_cnt_reg <= out_cnt_next;
			flags_reg <= flags_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			pair_reg <= pair_next;
			chan_reg <= chan_next;
			ochan_reg <= ochan_next;
			oval_reg <= oval_next;
			owr_reg <= owr_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rdata = rdata_reg;
	assign bus_rd_valid = rvalid_reg;
	assign out_wr = owr_reg;
	assign out_chan = ochan_reg;
	assign out_value = oval_reg;
	assign scan_start = scan_go;
	assign out_strobe = strobe_go;
	assign out_auto_update = ~ctrl_reg[`AIO_CTL_STRB_EN];
	assign input_mode_field = mode;
	assign loopback_active = (mode == AIO_MODE_LOOPBACK);
	// Loopback channel is only routed in loopback mode
	assign loopback_select = loopback_active ?
		ctrl_reg[`AIO_CTL_LOOP_HI:`AIO_CTL_LOOP_LO] : 3'h0;
	assign cal_mode = ctrl_reg[`AIO_CTL_CAL_HI:`AIO_CTL_CAL_LO];
	assign rate_value = rate_reg;
	assign rate_usage = use_reg;
	assign irq_req = ctrl_reg[`AIO_CTL_IRQ_FLAG];

	// Channels per scan; reserved code scans nothing
	always_comb begin
		unique case (mode)
			AIO_MODE_SE_CONT, AIO_MODE_SE_BURST: scan_chan_count = 4'h8;
			AIO_MODE_DIFF_CONT, AIO_MODE_DIFF_BURST: scan_chan_count = 4'h4;
			AIO_MODE_LOOPBACK: scan_chan_count = 4'h1;
			AIO_MODE_POS_REF, AIO_MODE_ZERO: scan_chan_count = 4'h8;
			AIO_MODE_RESERVED: scan_chan_count = 4'h0;
		endcase
	end

endmodule

// ===== src/aio_regs.svh
// Register offsets, control field positions, reset values and timing counts
`ifndef AIO_REGS_SVH
`define AIO_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets inside the 32-byte register block
// ----------------------------------------------------------------
`define AIO_OFF_CONTROL 5'h00
`define AIO_OFF_RATE 5'h04
`define AIO_OFF_DATA 5'h08
`define AIO_OFF_RATE_USE 5'h0c
`define AIO_OFF_IN_COUNT 5'h10
`define AIO_OFF_FLAGS 5'h14
`define AIO_OFF_FW_REV 5'h18
`define AIO_OFF_OUT_COUNT 5'h1c
`define AIO_BLOCK_LSB 5

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define AIO_CTL_MODE_LO 0
`define AIO_CTL_MODE_HI 2
`define AIO_CTL_LOOP_LO 3
`define AIO_CTL_LOOP_HI 5
`define AIO_CTL_STRB_EN 6
`define AIO_CTL_IRQ_LO 7
`define AIO_CTL_IRQ_HI 9
`define AIO_CTL_IRQ_FLAG 10
`define AIO_CTL_CAL_LO 11
`define AIO_CTL_CAL_HI 12
`define AIO_CTL_SW_STRB 13
`define AIO_CTL_BURST 14
`define AIO_CTL_INIT 15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AIO_CTRL_RESET 16'h2401
`define AIO_RATE_RESET 16'h0064
`define AIO_RATE_USE_RESET 16'h0000
`define AIO_COUNT_RESET 16'h0000
`define AIO_FLAGS_RESET 16'h0009

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AIO_CLK_MHZ 125
`define AIO_INIT_TIME_US 3000
`define AIO_INIT_CYCLES (`AIO_INIT_TIME_US * `AIO_CLK_MHZ)

`endif

// ===== src/aio_pkg.sv
// Types shared by the analog I/O register bank
package aio_pkg;

	typedef logic [15:0] aio_word_t;
	typedef logic [2:0] aio_mode_t;

	typedef enum logic {
		AIO_INIT_IDLE,
		AIO_INIT_RUN
	} aio_init_state_e;

	// Input mode codes
	localparam aio_mode_t AIO_MODE_SE_CONT = 3'h0;
	localparam aio_mode_t AIO_MODE_SE_BURST = 3'h1;
	localparam aio_mode_t AIO_MODE_DIFF_CONT = 3'h2;
	localparam aio_mode_t AIO_MODE_DIFF_BURST = 3'h3;
	localparam aio_mode_t AIO_MODE_LOOPBACK = 3'h4;
	localparam aio_mode_t AIO_MODE_POS_REF = 3'h5;
	localparam aio_mode_t AIO_MODE_RESERVED = 3'h6;
	localparam aio_mode_t AIO_MODE_ZERO = 3'h7;

endpackage

// ===== src/aio_fall_detect.sv
// Qualified falling-edge detector for a trigger or strobe pin
`timescale 1ns/10ps
module aio_fall_detect
	import aio_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Pin pair
	input wire logic pin,
	input wire logic ready,
	// Result
	output logic fall
);

	logic prev_reg;
	logic prev_next;

	always_comb begin
		prev_next = pin;
	end

	// Reset to high so a pin held low at release counts as an edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign fall = prev_reg & ~pin & ready;

endmodule

// ===== src/aio_init_timer.sv
// Initialization sequence timer
`timescale 1ns/10ps
`include "aio_regs.svh"
module aio_init_timer
	import aio_pkg::*;
#(
	parameter int CYCLES = `AIO_INIT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic start,
	output logic busy,
	output logic done
);

	aio_init_state_e state_reg;
	aio_init_state_e state_next;
	logic [19:0] cnt_reg;
	logic [19:0] cnt_next;
	logic done_next;
	logic done_reg;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		unique case (state_reg)
			AIO_INIT_IDLE: begin
				if (start) begin
					state_next = AIO_INIT_RUN;
					cnt_next = 20'h00000;
				end
			end
			AIO_INIT_RUN: begin
				if (cnt_reg >= 20'(CYCLES - 1)) begin
					state_next = AIO_INIT_IDLE;
					done_next = 1'b1;
				end else begin
					cnt_next = cnt_reg + 20'h00001;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= AIO_INIT_IDLE;
			cnt_reg <= 20'h00000;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign busy = (state_reg == AIO_INIT_RUN);
	assign done = done_reg;

endmodule

// ===== bench/aio_host_regs_properties.sv
// Port assertions for the host register bank
`timescale 1ns/10ps
module aio_host_regs_properties #(
	parameter int INIT_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register bus
	input wire logic [31:0] cfg_base_addr,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_hit,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_rd_valid,
	// Buffers and sequencer
	input wire logic in_pop,
	input wire logic in_buf_clear,
	input wire logic out_wr,
	input wire logic scan_active,
	input wire logic scan_start,
	input wire logic [3:0] scan_chan_count,
	// Modes, strobe and interrupt
	input wire logic out_strobe,
	input wire logic out_auto_update,
	input wire logic [2:0] input_mode_field,
	input wire logic [2:0] loopback_select,
	input wire logic loopback_active,
	input wire logic [1:0] cal_mode,
	input wire logic irq_req,
	input wire logic ext_strobe,
	input wire logic ext_update_armed
);
	// ----------------------------------------------------------------
	// Port assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic hit_rd;
	logic hit_wr;
	assign hit_rd = bus_rd && bus_hit;
	assign hit_wr = bus_wr && bus_hit;

	chk_hit_decode: assert property (
		bus_hit == (bus_addr[31:5] == cfg_base_addr[31:5]))
		else $error("bus hit does not match base compare");
	chk_read_answer: assert property (
		hit_rd |=> bus_rd_valid && bus_rdata[31:16] == 16'h0000)
		else $error("read not answered next cycle with zero upper half");
	chk_no_stray_valid: assert property (
		!hit_rd |=> !bus_rd_valid)
		else $error("read valid without a read");
	chk_pop_data_read: assert property (
		in_pop == (hit_rd && bus_addr[4:2] == 3'h2))
		else $error("input pop not tied to a data port read");
	chk_pair_write: assert property (
		out_wr |-> $past(hit_wr && bus_addr[4:2] == 3'h2) && !$past(out_wr))
		else $error("output write not closing a data port pair");
	chk_loopback_sel: assert property (
		loopback_active == (input_mode_field == 3'h4) && (loopback_active || loopback_select == 3'h0))
		else $error("loopback select outside loopback mode");
	chk_chan_count: assert property (
		scan_chan_count == (input_mode_field inside {3'h2, 3'h3} ? 4'h4 :
		input_mode_field == 3'h4 ? 4'h1 : input_mode_field == 3'h6 ? 4'h0 : 4'h8))
		else $error("scan channel count wrong for mode");
	// A start during a running scan would corrupt the sample order in the buffer
	chk_scan_start_gate: assert property (
		scan_start |-> !scan_active && input_mode_field inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h7})
		else $error("scan started while busy or not in burst mode");
	chk_init_done: assert property (
		in_buf_clear |=> irq_req && input_mode_field == 3'h1 && cal_mode == 2'h0 && out_auto_update)
		else $error("defaults not restored after initialization");
	chk_ext_strobe: assert property (
		out_strobe && !(hit_wr && bus_addr[4:2] == 3'h0)
		|-> $fell(ext_strobe) && ext_update_armed && !out_auto_update)
		else $error("output strobe without a qualified pin edge");
endmodule

bind aio_host_regs aio_host_regs_properties #(.INIT_CYCLES(INIT_CYCLES)) u_props (
	.clk, .rst_b, .cfg_base_addr, .bus_addr, .bus_wr, .bus_rd, .bus_hit, .bus_rdata,
	.bus_rd_valid, .in_pop, .in_buf_clear, .out_wr, .scan_active, .scan_start,
	.scan_chan_count, .out_strobe, .out_auto_update, .input_mode_field, .loopback_select,
	.loopback_active, .cal_mode, .irq_req, .ext_strobe, .ext_update_armed
);

// ===== bench/aio_host_model.sv
// Host bus master model that reaches the register bank
`timescale 1ns/10ps
module aio_host_model (
	// Clock
	input wire logic clk,
	// Register bus
	input wire logic [31:0] cfg_base_addr,
	output logic [31:0] bus_addr,
	output logic bus_wr,
	output logic bus_rd,
	output logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_rd_valid
);
	logic hung;
	initial begin
		bus_addr = 32'h0;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		hung = 1'b0;
	end
	// One single-word cycle; released lines show the inverse so stale values never match
	task automatic go(input logic wr, input logic [4:0] off, input logic [15:0] d);
		@(posedge clk);
		#1;
		bus_addr = {cfg_base_addr[31:5], off};
		bus_wdata = {~d, d};
		bus_wr = wr;
		bus_rd = !wr;
		@(posedge clk);
		#1;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = ~bus_addr;
		bus_wdata = ~bus_wdata;
	endtask
	task automatic wr(input logic [4:0] off, input logic [15:0] d);
		go(1'b1, off, d);
	endtask
	task automatic rd(input logic [4:0] off, output logic [31:0] d);
		int n;
		go(1'b0, off, 16'h0000);
		n = 0;
		while (bus_rd_valid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		hung = (n == 4);
		d = bus_rdata;
	endtask
	// Output data always goes as channel word then value word
	task automatic pair(input logic [2:0] chan, input logic [15:0] value);
		go(1'b1, 5'h08, {13'h0, chan});
		go(1'b1, 5'h08, value);
	endtask
endmodule

// ===== bench/aio_host_regs_tb.sv
// Self-checking bench for the host register bank
`timescale 1ns/10ps
module aio_host_regs_tb;
	localparam int INIT = 20;
	localparam logic [15:0] RST [8] = '{16'h2401, 16'h0064, 16'h0000, 16'h0000,
		16'h0000, 16'h0009, 16'h0100, 16'h0000};
	localparam logic [3:0] CNT [8] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 4'h8, 4'h0, 4'h8};
	logic clk, rst_b, bus_wr, bus_rd, bus_hit, bus_rd_valid, in_pop, in_buf_clear, out_wr;
	logic scan_active, scan_done, scan_start, update_done, out_strobe, out_auto_update;
	logic loopback_active, irq_req, ext_trig, ext_trig_ready, ext_strobe, ext_update_armed;
	logic [31:0] base, host_base, bus_addr, bus_wdata, bus_rdata, rd;
	logic [15:0] in_sample, in_count, buf_flags, out_count, out_value, rate_value, rate_usage;
	logic [2:0] out_chan, input_mode_field, loopback_select;
	logic [1:0] cal_mode;
	logic [3:0] scan_chan_count;
	logic [7:0] irq_cond;
	int mismatches, num_checks, strobes, starts, n;

	aio_host_regs #(.INIT_CYCLES(INIT)) dut (.clk, .rst_b, .cfg_base_addr(base), .bus_addr,
		.bus_wr, .bus_rd, .bus_wdata, .bus_hit, .bus_rdata, .bus_rd_valid, .in_sample,
		.in_count, .buf_flags, .in_pop, .in_buf_clear, .out_count, .out_wr, .out_chan,
		.out_value, .scan_active, .scan_done, .scan_start, .scan_chan_count, .update_done,
		.out_strobe, .out_auto_update, .input_mode_field, .loopback_select, .loopback_active,
		.cal_mode, .rate_value, .rate_usage, .irq_cond, .irq_req, .ext_trig, .ext_trig_ready,
		.ext_strobe, .ext_update_armed);
	aio_host_model host (.clk, .cfg_base_addr(host_base), .bus_addr, .bus_wr, .bus_rd,
		.bus_wdata, .bus_rdata, .bus_rd_valid);

	// ----------------------------------------------------------------
	// Clock, counters and tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (out_strobe === 1'b1) strobes++;
		if (scan_start === 1'b1) starts++;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input string what, input logic [4:0] off, input logic [15:0] e);
		host.rd(off, rd);
		if (host.hung) begin
			mismatches++;
			summarize();
		end else begin
			cmp(what, {16'h0000, e}, rd);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{rst_b, scan_active, scan_done, update_done, ext_update_armed} = 5'h00;
		{ext_trig, ext_trig_ready, ext_strobe} = 3'h7;
		{in_sample, in_count, out_count, irq_cond} = 56'h0;
		buf_flags = 16'h0009;
		base = 32'h8000_0100;
		host_base = base;
		{mismatches, num_checks, strobes, starts} = 128'h0;
		step(6);
		rst_b = 1'b1;
		for (int i = 0; i < 8; i++) rchk("reset value", 5'(i * 4), RST[i]);
		host.wr(5'h04, 16'h1234);
		host.wr(5'h0c, 16'h00a5);
		host.wr(5'h10, 16'hffff);
		host.wr(5'h1c, 16'hffff);
		{in_count, out_count, buf_flags, in_sample} = 64'h0005_0003_0006_8000;
		host_base = 32'h9000_0000;
		host.wr(5'h04, 16'hbeef);
		host_base = base;
		rchk("rate", 5'h04, 16'h1234);
		rchk("rate use", 5'h0c, 16'h00a5);
		cmp("rate outputs", {16'h00a5, 16'h1234}, {rate_usage, rate_value});
		rchk("in count", 5'h10, 16'h0005);
		rchk("flags", 5'h14, 16'h0006);
		rchk("out count", 5'h1c, 16'h0003);
		rchk("sample", 5'h08, 16'h8000);
		host.pair(3'h5, 16'habcd);
		cmp("out pair", {1'b1, 3'h5, 16'habcd}, {out_wr, out_chan, out_value});
		for (int s = 0; s < 8; s++) begin
			host.wr(5'h00, {6'h0, s[2:0], 7'h01});
			cmp("irq clear", 1'b0, irq_req);
			irq_cond = 8'h01 << s;
			step(1);
			irq_cond = 8'h00;
			step(1);
			cmp("irq set", 1'b1, irq_req);
		end
		update_done = 1'b1;
		step(1);
		update_done = 1'b0;
		rchk("ctrl", 5'h00, 16'h0781);
		n = strobes;
		host.wr(5'h00, 16'h2001);
		host.wr(5'h00, 16'h2001);
		cmp("sw strobes", n + 1, strobes);
		host.wr(5'h00, 16'h2041);
		cmp("auto update", 1'b0, out_auto_update);
		update_done = 1'b1;
		for (int a = 0; a < 2; a++) begin
			step(1);
			{update_done, ext_update_armed, ext_strobe} = {1'b0, a[0], 1'b0};
			step(1);
			ext_strobe = 1'b1;
		end
		cmp("ext strobes", n + 2, strobes);
		n = starts;
		host.wr(5'h00, 16'h4001);
		rchk("ctrl burst", 5'h00, 16'h6001);
		scan_active = 1'b1;
		host.wr(5'h00, 16'h4001);
		ext_trig = 1'b0;
		step(1);
		{ext_trig, scan_active, scan_done} = 3'b101;
		step(1);
		scan_done = 1'b0;
		cmp("busy starts", n + 1, starts);
		rchk("ctrl done", 5'h00, 16'h2001);
		{ext_trig, ext_trig_ready} = 2'b00;
		step(1);
		{ext_trig, ext_trig_ready} = 2'b11;
		step(1);
		ext_trig = 1'b0;
		step(1);
		{ext_trig, scan_done} = 2'b11;
		cmp("trig starts", n + 2, starts);
		step(1);
		scan_done = 1'b0;
		host.wr(5'h00, 16'h0000);
		host.wr(5'h00, 16'h4000);
		cmp("cont starts", n + 2, starts);
		for (int m = 0; m < 8; m++) begin
			host.wr(5'h00, {3'h0, m[1:0], 5'h00, 3'h5, m[2:0]});
			cmp("loop sel", (m == 4) ? 3'h5 : 3'h0, loopback_select);
			cmp("chan count", CNT[m], scan_chan_count);
			cmp("cal mode", m[1:0], cal_mode);
		end
		host.wr(5'h00, 16'h8007);
		rchk("init busy", 5'h00, 16'ha007);
		n = 0;
		while (in_buf_clear !== 1'b1 && n < INIT + 10) begin
			step(1);
			n++;
		end
		cmp("init time", 1'b1, n <= INIT + 2);
		step(1);
		rchk("ctrl after init", 5'h00, 16'h2401);
		rchk("rate after init", 5'h04, 16'h0064);
		summarize();
	end
endmodule
